// ==== hdl/lpc_pkg.sv ====
// Package: constants and carrier types for the parameter and cursor register block
package lpc_pkg;

   // ----------------------------------------------------------------
   // Instruction codes
   // ----------------------------------------------------------------
   localparam logic [7:0] CODE_HORIZ_COUNT  = 8'h02;
   localparam logic [7:0] CODE_TIME_DIV     = 8'h03;
   localparam logic [7:0] CODE_CURSOR_ROW   = 8'h04;
   localparam logic [7:0] CODE_START_LOW    = 8'h08;
   localparam logic [7:0] CODE_START_HIGH   = 8'h09;
   localparam logic [7:0] CODE_PTR_LOW      = 8'h0A;
   localparam logic [7:0] CODE_PTR_HIGH     = 8'h0B;

   // ----------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------
   localparam int          COUNT_FIELD_W    = 7;
   localparam int          ROW_FIELD_W      = 4;
   localparam int          BUSY_BIT_POS     = 7;
   localparam int          CHAR_HIGH_W      = 4;
   localparam logic [2:0]  PITCH_CODE_6     = 3'h5;
   localparam logic [2:0]  PITCH_CODE_7     = 3'h6;
   localparam logic [2:0]  PITCH_CODE_8     = 3'h7;
   localparam logic [3:0]  PITCH_DOTS_6     = 4'h6;
   localparam logic [3:0]  PITCH_DOTS_7     = 4'h7;
   localparam logic [3:0]  PITCH_DOTS_8     = 4'h8;
   localparam logic [7:0]  REG_RESET        = 8'h00;
   localparam logic [15:0] ADDR_RESET       = 16'h0000;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int          CLK_PERIOD_NS    = 50;
   localparam int          EXEC_TIME_NS     = 4000;
   localparam int          EXEC_CYCLES      = EXEC_TIME_NS / CLK_PERIOD_NS;
   localparam logic [6:0]  EXEC_LAST        = 7'(EXEC_CYCLES - 1);

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       register_select;
      logic       read_not_write;
      logic       enable;
      logic [7:0] host_data_bus;
   } lpc_pins_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } lpc_state_type;

endpackage

// ==== hdl/lpc_sync.sv ====
// Two-stage synchroniser for the host pin group
`timescale 1ns/1ns
module lpc_sync import lpc_pkg::*; (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire lpc_pins_type  pins_async,
   output lpc_pins_type       pins_sync
);

   lpc_pins_type stage1_ff;
   lpc_pins_type stage2_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
      end else begin
         stage1_ff <= pins_async;
         stage2_ff <= stage1_ff;
      end
   end

   assign pins_sync = stage2_ff;

endmodule

// ==== hdl/lpc_ram_pointer.sv ====
// Loadable 16-bit RAM pointer with ripple carry on low-byte load
`timescale 1ns/1ns
module lpc_ram_pointer import lpc_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        load_low,
   input  wire logic        load_high,
   input  wire logic        advance,
   input  wire logic [7:0]  load_data,
   output logic      [15:0] pointer
);

   logic [15:0] pointer_ff;
   logic [15:0] nxt_pointer;
   logic        low_carry;

   // ----------------------------------------------------------------
   // Next value
   // ----------------------------------------------------------------
   assign low_carry   = pointer_ff[7] & ~load_data[7];
   assign nxt_pointer = load_high ? {load_data, pointer_ff[7:0]} :
                        load_low  ? {pointer_ff[15:8] + 8'(low_carry), load_data} :
                        advance   ? pointer_ff + 16'h0001 :
                        pointer_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pointer_ff <= ADDR_RESET;
      end else begin
         pointer_ff <= nxt_pointer;
      end
   end

   assign pointer = pointer_ff;

endmodule

// ==== hdl/lpc_param_regs.sv ====
// Display parameter and cursor address instruction block
`timescale 1ns/1ns
module lpc_param_regs import lpc_pkg::*; (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        register_select,
   input  wire logic        read_not_write,
   input  wire logic        enable,
   input  wire logic [7:0]  host_data_bus_in,
   output logic      [7:0]  host_data_bus_out,
   output logic             host_data_bus_oe,
   input  wire logic [2:0]  horizontal_pitch,
   input  wire logic [3:0]  vertical_pitch,
   input  wire logic        graphic_mode,
   input  wire logic        cursor_enable,
   input  wire logic        data_access_done,
   input  wire logic        frame_begin,
   input  wire logic        fetch_advance,
   input  wire logic [3:0]  scan_row,
   input  wire logic [15:0] scan_addr,
   input  wire logic        char_dot,
   output logic             busy_flag_bit,
   output logic [6:0]       horizontal_count,
   output logic [6:0]       time_divisions,
   output logic [3:0]       cursor_row,
   output logic [15:0]      frame_start_addr,
   output logic [15:0]      ram_address,
   output logic [15:0]      fetch_addr,
   output logic [3:0]       pitch_dots,
   output logic [10:0]      line_dots,
   output logic [7:0]       duty_divisor,
   output logic [3:0]       cursor_run_dots,
   output logic             display_dot
);

   // ----------------------------------------------------------------
   // Pin synchronisation
   // ----------------------------------------------------------------
   lpc_pins_type pins_raw;
   lpc_pins_type pins;

   assign pins_raw = '{register_select : register_select,
                       read_not_write  : read_not_write,
                       enable          : enable,
                       host_data_bus   : host_data_bus_in};

   lpc_sync u_sync (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .pins_async (pins_raw),
      .pins_sync  (pins)
   );

   // ----------------------------------------------------------------
   // Strobe decode
   // ----------------------------------------------------------------
   logic enable_d_ff;
   wire  enable_fall  = enable_d_ff & ~pins.enable;
   wire  write_fall   = enable_fall & ~pins.read_not_write;
   wire  code_write   = write_fall & pins.register_select;
   wire  param_write  = write_fall & ~pins.register_select;
   wire  status_read  = pins.enable & pins.read_not_write & pins.register_select;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enable_d_ff <= 1'b0;
      end else begin
         enable_d_ff <= pins.enable;
      end
   end

   // ----------------------------------------------------------------
   // Instruction register and execution sequencer
   // ----------------------------------------------------------------
   lpc_state_type state_ff;
   lpc_state_type nxt_state;
   logic [7:0]    code_ff;
   logic [6:0]    exec_cnt_ff;
   logic [6:0]    nxt_exec_cnt;

   wire sel_count   = code_ff == CODE_HORIZ_COUNT;
   wire sel_div     = code_ff == CODE_TIME_DIV;
   wire sel_row     = code_ff == CODE_CURSOR_ROW;
   wire sel_st_lo   = code_ff == CODE_START_LOW;
   wire sel_st_hi   = code_ff == CODE_START_HIGH;
   wire sel_ptr_lo  = code_ff == CODE_PTR_LOW;
   wire sel_ptr_hi  = code_ff == CODE_PTR_HIGH;
   wire known_code  = sel_count | sel_div | sel_row | sel_st_lo |
                      sel_st_hi | sel_ptr_lo | sel_ptr_hi;

   // Writes while busy are dropped, as the host must poll first
   wire not_busy    = state_ff != ST_BUSY;
   wire code_take   = code_write & not_busy;
   wire exec_go     = param_write & (state_ff == ST_ARMED) & known_code;
   wire exec_done   = (state_ff == ST_BUSY) & (exec_cnt_ff == EXEC_LAST);

   always_comb begin
      nxt_state    = state_ff;
      nxt_exec_cnt = exec_cnt_ff;
      case (state_ff)
         ST_IDLE: begin
            if (code_take) begin
               nxt_state = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (exec_go) begin
               nxt_state    = ST_BUSY;
               nxt_exec_cnt = 7'h00;
            end
         end
         ST_BUSY: begin
            nxt_exec_cnt = exec_cnt_ff + 7'h01;
            if (exec_done) begin
               nxt_state    = ST_ARMED;
               nxt_exec_cnt = 7'h00;
            end
         end
         default: begin
            nxt_state    = ST_IDLE;
            nxt_exec_cnt = 7'h00;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff    <= ST_IDLE;
         exec_cnt_ff <= 7'h00;
         code_ff     <= REG_RESET;
      end else begin
         state_ff    <= nxt_state;
         exec_cnt_ff <= nxt_exec_cnt;
         if (code_take) begin
            code_ff <= pins.host_data_bus;
         end
      end
   end

   // ----------------------------------------------------------------
   // Parameter registers
   // ----------------------------------------------------------------
   logic [6:0]  horizontal_count_ff;
   logic [6:0]  time_divisions_ff;
   logic [3:0]  cursor_row_ff;
   logic [7:0]  start_low_ff;
   logic [7:0]  start_high_ff;
   wire  [7:0]  pdata = pins.host_data_bus;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         horizontal_count_ff <= REG_RESET[COUNT_FIELD_W-1:0];
         time_divisions_ff   <= REG_RESET[COUNT_FIELD_W-1:0];
         cursor_row_ff       <= REG_RESET[ROW_FIELD_W-1:0];
         start_low_ff        <= REG_RESET;
         start_high_ff       <= REG_RESET;
      end else if (exec_go) begin
         if (sel_count) begin
            horizontal_count_ff <= pdata[COUNT_FIELD_W-1:0];
         end
         if (sel_div) begin
            time_divisions_ff <= pdata[COUNT_FIELD_W-1:0];
         end
         if (sel_row) begin
            cursor_row_ff <= pdata[ROW_FIELD_W-1:0];
         end
         if (sel_st_lo) begin
            start_low_ff <= pdata;
         end
         if (sel_st_hi) begin
            start_high_ff <= pdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // RAM pointer
   // ----------------------------------------------------------------
   logic [15:0] pointer;

   lpc_ram_pointer u_pointer (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .load_low  (exec_go & sel_ptr_lo),
      .load_high (exec_go & sel_ptr_hi),
      .advance   (data_access_done),
      .load_data (pdata),
      .pointer   (pointer)
   );

   // ----------------------------------------------------------------
   // Derived display geometry
   // ----------------------------------------------------------------
   logic [3:0]  pitch_sel;
   wire  [7:0]  count_plus = {1'b0, horizontal_count_ff} + 8'h01;
   wire  [10:0] dots_prod  = 11'(pitch_sel) * 11'(count_plus);
   wire  [7:0]  div_plus   = {1'b0, time_divisions_ff} + 8'h01;

   always_comb begin
      case (horizontal_pitch)
         PITCH_CODE_6: pitch_sel = PITCH_DOTS_6;
         PITCH_CODE_7: pitch_sel = PITCH_DOTS_7;
         PITCH_CODE_8: pitch_sel = PITCH_DOTS_8;
         default:      pitch_sel = PITCH_DOTS_8;
      endcase
   end

   // Character mode drops the high nibble of the start address
   wire [15:0] start_full = {start_high_ff, start_low_ff};
   wire [15:0] start_used = graphic_mode ? start_full :
                            {{CHAR_HIGH_W{1'b0}}, start_full[11:0]};

   // ----------------------------------------------------------------
   // Frame fetch address
   // ----------------------------------------------------------------
   logic [15:0] fetch_addr_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         fetch_addr_ff <= ADDR_RESET;
      end else if (frame_begin) begin
         fetch_addr_ff <= start_used;
      end else if (fetch_advance) begin
         fetch_addr_ff <= fetch_addr_ff + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Cursor overlay
   // ----------------------------------------------------------------
   wire [15:0] ptr_cmp    = graphic_mode ? pointer :
                            {{CHAR_HIGH_W{1'b0}}, pointer[11:0]};
   wire [15:0] scan_cmp   = graphic_mode ? scan_addr :
                            {{CHAR_HIGH_W{1'b0}}, scan_addr[11:0]};
   wire        row_fits   = cursor_row_ff <= vertical_pitch;
   wire        on_cell    = ptr_cmp == scan_cmp;
   // Whole cell row is lit, so run length tracks the pitch
   wire        cursor_hit = cursor_enable & ~graphic_mode & row_fits &
                            on_cell & (scan_row == cursor_row_ff);
   wire        dot_next   = cursor_hit | char_dot;

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   logic [7:0]  bus_out_ff;
   logic        bus_oe_ff;
   logic [3:0]  pitch_dots_ff;
   logic [10:0] line_dots_ff;
   logic [7:0]  duty_divisor_ff;
   logic        display_dot_ff;
   logic [15:0] ram_address_ff;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus_out_ff      <= REG_RESET;
         bus_oe_ff       <= 1'b0;
         pitch_dots_ff   <= PITCH_DOTS_8;
         line_dots_ff    <= 11'h000;
         duty_divisor_ff <= REG_RESET;
         display_dot_ff  <= 1'b0;
         ram_address_ff  <= ADDR_RESET;
      end else begin
         bus_out_ff      <= {~not_busy, 7'h00};
         bus_oe_ff       <= status_read;
         pitch_dots_ff   <= pitch_sel;
         line_dots_ff    <= dots_prod;
         duty_divisor_ff <= div_plus;
         display_dot_ff  <= dot_next;
         ram_address_ff  <= pointer;
      end
   end

   assign host_data_bus_out = bus_out_ff;
   assign host_data_bus_oe  = bus_oe_ff;
   assign busy_flag_bit     = bus_out_ff[BUSY_BIT_POS];
   assign horizontal_count  = horizontal_count_ff;
   assign time_divisions    = time_divisions_ff;
   assign cursor_row        = cursor_row_ff;
   assign frame_start_addr  = start_full;
   assign ram_address       = ram_address_ff;
   assign fetch_addr        = fetch_addr_ff;
   assign pitch_dots        = pitch_dots_ff;
   assign line_dots         = line_dots_ff;
   assign duty_divisor      = duty_divisor_ff;
   assign cursor_run_dots   = pitch_dots_ff;
   assign display_dot       = display_dot_ff;

endmodule

// ==== verification/lpc_param_regs_assertions.sv ====
// Checker: timing relations at the ports of the parameter register block
`timescale 1ns/1ns
module lpc_param_regs_checker import lpc_pkg::*; (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [2:0]  horizontal_pitch,
   input wire logic [3:0]  vertical_pitch,
   input wire logic        graphic_mode,
   input wire logic        cursor_enable,
   input wire logic        data_access_done,
   input wire logic        frame_begin,
   input wire logic        char_dot,
   input wire logic        busy_flag_bit,
   input wire logic [6:0]  horizontal_count,
   input wire logic [6:0]  time_divisions,
   input wire logic [3:0]  cursor_row,
   input wire logic [15:0] frame_start_addr,
   input wire logic [15:0] ram_address,
   input wire logic [15:0] fetch_addr,
   input wire logic [3:0]  pitch_dots,
   input wire logic [10:0] line_dots,
   input wire logic [7:0]  duty_divisor,
   input wire logic [3:0]  cursor_run_dots,
   input wire logic        display_dot
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   logic [7:0] busy_run_ff;
   logic [7:0] nxt_busy_run;
   logic [3:0] exp_dots;

   assign nxt_busy_run = busy_flag_bit ? busy_run_ff + 8'h1 : 8'h0;
   assign exp_dots     = (horizontal_pitch == PITCH_CODE_6) ? PITCH_DOTS_6 :
                         (horizontal_pitch == PITCH_CODE_7) ? PITCH_DOTS_7 : PITCH_DOTS_8;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) busy_run_ff <= 8'h0;
      else busy_run_ff <= nxt_busy_run;
   end

   sequence s_adv;
      data_access_done ##1 !data_access_done;
   endsequence
   sequence s_settle;
      ($stable(pitch_dots) && $stable(horizontal_count))[*3];
   endsequence

   property p_pitch;
      1'b1 |=> pitch_dots == $past(exp_dots) && cursor_run_dots == $past(exp_dots);
   endproperty
   property p_line;
      s_settle |-> line_dots == 11'(pitch_dots) * (11'(horizontal_count) + 11'h1);
   endproperty
   property p_duty;
      $stable(time_divisions)[*2] |-> duty_divisor == 8'(time_divisions) + 8'h1;
   endproperty
   property p_busy_len;
      ($fell(busy_flag_bit) |-> busy_run_ff == 8'(EXEC_CYCLES)) and
      (busy_flag_bit |-> busy_run_ff < 8'(EXEC_CYCLES));
   endproperty
   property p_reg_busy;
      !$stable({horizontal_count, time_divisions, cursor_row, frame_start_addr})
         |=> $rose(busy_flag_bit);
   endproperty
   property p_advance;
      s_adv |=> ram_address == $past(ram_address) + 16'h1;
   endproperty
   property p_frame;
      frame_begin |=> fetch_addr == ($past(graphic_mode) ? $past(frame_start_addr)
                                     : $past(frame_start_addr) & 16'h0FFF);
   endproperty
   property p_no_cursor;
      !char_dot && (graphic_mode || !cursor_enable || cursor_row > vertical_pitch)
         |=> !display_dot;
   endproperty

   a_pitch: assert property (p_pitch) else $error("pitch dots wrong");
   a_line: assert property (p_line) else $error("line dots wrong");
   a_duty: assert property (p_duty) else $error("duty divisor wrong");
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   a_reg_busy: assert property (p_reg_busy) else $error("store without busy");
   a_advance: assert property (p_advance) else $error("pointer did not advance");
   a_frame: assert property (p_frame) else $error("frame fetch start wrong");
   a_no_cursor: assert property (p_no_cursor) else $error("cursor shown");
endmodule

bind lpc_param_regs lpc_param_regs_checker u_lpc_param_regs_checker (
   .ref_clk(ref_clk), .rst_n(rst_n), .horizontal_pitch(horizontal_pitch),
   .vertical_pitch(vertical_pitch), .graphic_mode(graphic_mode),
   .cursor_enable(cursor_enable), .data_access_done(data_access_done),
   .frame_begin(frame_begin), .char_dot(char_dot), .busy_flag_bit(busy_flag_bit),
   .horizontal_count(horizontal_count), .time_divisions(time_divisions),
   .cursor_row(cursor_row), .frame_start_addr(frame_start_addr),
   .ram_address(ram_address), .fetch_addr(fetch_addr), .pitch_dots(pitch_dots),
   .line_dots(line_dots), .duty_divisor(duty_divisor),
   .cursor_run_dots(cursor_run_dots), .display_dot(display_dot));

// ==== verification/lpc_host_model.sv ====
// Host processor model writing instructions and polling busy
`timescale 1ns/1ns
module lpc_host_model import lpc_pkg::*; (
   input  wire logic       ref_clk,
   input  wire logic [7:0] host_data_bus_out,
   input  wire logic       host_data_bus_oe,
   output logic            register_select,
   output logic            read_not_write,
   output logic            enable,
   output logic [7:0]      host_data_bus_in
);
   logic [7:0] status_ff = 8'hFF;
   logic       hung      = 1'b0;

   initial begin
      register_select  = 1'b0;
      read_not_write   = 1'b0;
      enable           = 1'b0;
      host_data_bus_in = 8'h00;
   end

   // Strobe held long enough for the pin synchroniser on both edges
   task automatic strobe(input logic rs, input logic rw, input logic [7:0] d);
      @(posedge ref_clk);
      #2;
      register_select  = rs;
      read_not_write   = rw;
      host_data_bus_in = d;
      enable           = 1'b1;
      repeat (5) @(posedge ref_clk);
      status_ff = host_data_bus_oe ? host_data_bus_out : 8'hFF;
      #2;
      enable = 1'b0;
      repeat (5) @(posedge ref_clk);
      #2;
      host_data_bus_in = ~d;
   endtask

   task automatic wait_ready;
      int polls = 0;
      do begin
         strobe(1'b1, 1'b1, ~host_data_bus_in);
         polls++;
      end while (status_ff[BUSY_BIT_POS] !== 1'b0 && polls < 40);
      if (status_ff[BUSY_BIT_POS] !== 1'b0) hung = 1'b1;
   endtask

   task automatic instr(input logic [7:0] code, input logic [7:0] data);
      strobe(1'b1, 1'b0, code);
      strobe(1'b0, 1'b0, data);
      wait_ready();
   endtask
endmodule

// ==== verification/lpc_param_regs_tb_top.sv ====
// Testbench: parameter and cursor register block against a bench model
`timescale 1ns/1ns
module lpc_param_regs_tb_top;
   import lpc_pkg::*;
   logic        ref_clk = 1'b0, rst_n = 1'b0, graphic_mode = 1'b0, cursor_enable = 1'b0;
   logic        data_access_done = 1'b0, frame_begin = 1'b0, fetch_advance = 1'b0;
   logic        char_dot = 1'b0, scan_hold = 1'b0;
   logic [2:0]  horizontal_pitch = PITCH_CODE_6;
   logic [3:0]  vertical_pitch = 4'h0, scan_row = 4'h0;
   logic [15:0] scan_addr = 16'h0000, exp_ptr;
   logic [7:0]  lo;
   logic [7:0]  lows[$] = '{8'h80, 8'h05, 8'hFF, 8'h7E};
   wire logic   register_select, read_not_write, enable, host_data_bus_oe, busy_flag_bit;
   wire logic   display_dot;
   wire logic [7:0]  host_data_bus_in, host_data_bus_out, duty_divisor;
   wire logic [6:0]  horizontal_count, time_divisions;
   wire logic [3:0]  cursor_row, pitch_dots, cursor_run_dots;
   wire logic [15:0] frame_start_addr, ram_address, fetch_addr;
   wire logic [10:0] line_dots;
   int          n_fail = 0, num_checks = 0, i, n, exp_cnt;
   integer      seed = 32'hcaaf;

   always #25 ref_clk = ~ref_clk;

   lpc_host_model u_lpc_host_model (.ref_clk(ref_clk), .host_data_bus_out(host_data_bus_out),
      .host_data_bus_oe(host_data_bus_oe), .register_select(register_select),
      .read_not_write(read_not_write), .enable(enable), .host_data_bus_in(host_data_bus_in));

   lpc_param_regs u_lpc_param_regs (.ref_clk(ref_clk), .rst_n(rst_n),
      .register_select(register_select), .read_not_write(read_not_write), .enable(enable),
      .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
      .host_data_bus_oe(host_data_bus_oe), .horizontal_pitch(horizontal_pitch),
      .vertical_pitch(vertical_pitch), .graphic_mode(graphic_mode),
      .cursor_enable(cursor_enable), .data_access_done(data_access_done),
      .frame_begin(frame_begin), .fetch_advance(fetch_advance), .scan_row(scan_row),
      .scan_addr(scan_addr), .char_dot(char_dot), .busy_flag_bit(busy_flag_bit),
      .horizontal_count(horizontal_count), .time_divisions(time_divisions),
      .cursor_row(cursor_row), .frame_start_addr(frame_start_addr),
      .ram_address(ram_address), .fetch_addr(fetch_addr), .pitch_dots(pitch_dots),
      .line_dots(line_dots), .duty_divisor(duty_divisor),
      .cursor_run_dots(cursor_run_dots), .display_dot(display_dot));

   // Random scan traffic
   always @(posedge ref_clk) begin
      #2;
      if (!scan_hold) begin
         char_dot       = 1'($random(seed));
         cursor_enable  = 1'($random(seed));
         scan_row       = 4'($random(seed));
         vertical_pitch = 4'($random(seed));
         scan_addr      = 16'($random(seed));
      end
   end

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic pulse(ref logic s);
      @(posedge ref_clk);
      #2;
      s = 1'b1;
      @(posedge ref_clk);
      #2;
      s = 1'b0;
      @(posedge ref_clk);
      #2;
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      #(50 * 40000);
      n_fail++;
      $display("watchdog expired");
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge ref_clk);
      #2;
      rst_n = 1'b1;
      for (i = 0; i < 3; i++) begin
         horizontal_pitch = PITCH_CODE_6 + 3'(i);
         n = 2 + 2 * ({$random(seed)} % 64);
         exp_cnt = n - 1;
         u_lpc_host_model.instr(CODE_HORIZ_COUNT, 8'(exp_cnt));
         chk("horizontal_count", 16'(exp_cnt), 16'(horizontal_count));
         chk("pitch_dots", 16'(6 + i), 16'(pitch_dots));
         chk("cursor_run_dots", 16'(6 + i), 16'(cursor_run_dots));
         chk("line_dots", 16'((6 + i) * n), 16'(line_dots));
         n = 1 + {$random(seed)} % 128;
         u_lpc_host_model.instr(CODE_TIME_DIV, 8'(n - 1));
         chk("time_divisions", 16'(n - 1), 16'(time_divisions));
         chk("duty_divisor", 16'(n), 16'(duty_divisor));
         n = 1 + {$random(seed)} % 16;
         u_lpc_host_model.instr(CODE_CURSOR_ROW, 8'(n - 1));
         chk("cursor_row", 16'(n - 1), 16'(cursor_row));
         chk("horizontal_count", 16'(exp_cnt), 16'(horizontal_count));
      end
      $display("test parameters done");
      u_lpc_host_model.instr(CODE_START_LOW, 8'hA5);
      u_lpc_host_model.instr(CODE_START_HIGH, 8'hC3);
      chk("frame_start_addr", 16'hC3A5, frame_start_addr);
      for (i = 0; i < 2; i++) begin
         graphic_mode = 1'(i);
         pulse(frame_begin);
         exp_ptr = (i == 1) ? 16'hC3A5 : 16'h03A5;
         chk("fetch_addr", exp_ptr, fetch_addr);
         pulse(fetch_advance);
         chk("fetch_addr", exp_ptr + 16'h1, fetch_addr);
      end
      $display("test start address done");
      u_lpc_host_model.instr(CODE_PTR_HIGH, 8'h12);
      exp_ptr = 16'h1200;
      foreach (lows[k]) begin
         lo = lows[k];
         u_lpc_host_model.instr(CODE_PTR_LOW, lo);
         exp_ptr = {exp_ptr[15:8] + 8'(exp_ptr[7] & ~lo[7]), lo};
         chk("ram_address", exp_ptr, ram_address);
      end
      u_lpc_host_model.instr(CODE_PTR_HIGH, 8'h12);
      exp_ptr = {8'h12, lo};
      chk("ram_address", exp_ptr, ram_address);
      pulse(data_access_done);
      chk("ram_address", exp_ptr + 16'h1, ram_address);
      $display("test pointer done");
      u_lpc_host_model.instr(CODE_CURSOR_ROW, 8'h03);
      scan_hold      = 1'b1;
      graphic_mode   = 1'b0;
      cursor_enable  = 1'b1;
      char_dot       = 1'b0;
      scan_row       = 4'h3;
      vertical_pitch = 4'h7;
      scan_addr      = 16'hA27F;
      @(posedge ref_clk);
      #2;
      chk("display_dot", 16'h0001, 16'(display_dot));
      vertical_pitch = 4'h2;
      @(posedge ref_clk);
      #2;
      chk("display_dot", 16'h0000, 16'(display_dot));
      scan_hold = 1'b0;
      $display("test cursor done");
      u_lpc_host_model.instr(8'h05, 8'h33);
      chk("horizontal_count", 16'(exp_cnt), 16'(horizontal_count));
      u_lpc_host_model.strobe(1'b1, 1'b0, CODE_HORIZ_COUNT);
      u_lpc_host_model.strobe(1'b0, 1'b0, 8'h0F);
      u_lpc_host_model.strobe(1'b0, 1'b0, 8'h1F);
      u_lpc_host_model.wait_ready();
      chk("horizontal_count", 16'h000F, 16'(horizontal_count));
      chk("host_hang", 16'h0000, 16'(u_lpc_host_model.hung));
      chk("status_byte", 16'h0000, 16'(u_lpc_host_model.status_ff));
      $display("test refusal done");
      tally_and_finish();
   end
endmodule
